// >>> hdl/usd_pkg.sv
/*
 shared constants and carriers for the serial data shadow port.
 assumes a 125 MHz system clock and a 32-bit classic wishbone bus.
*/
package usd_pkg;
   localparam int USD_CLK_HZ = 125000000;
   localparam int USD_BAUD = 115200;
   localparam logic [10:0] USD_BIT_LAST = 11'(USD_CLK_HZ / USD_BAUD - 1);
   localparam logic [10:0] USD_BIT_HALF = 11'(USD_CLK_HZ / USD_BAUD / 2);
   localparam logic [10:0] USD_IR_CYC = 11'((USD_CLK_HZ / USD_BAUD) * 3 / 16);
   localparam logic [3:0] USD_LAST_SLOT = 4'h9;
   localparam int USD_DEPTH = 16;
   localparam logic [4:0] USD_DEPTH_CNT = 5'h10;
   localparam logic [4:0] USD_ONE_CNT = 5'h01;
   localparam logic [31:0] USD_WIN_FIRST = 32'h50001030;
   localparam logic [31:0] USD_WIN_LAST = 32'h5000106c;
   localparam logic [31:0] USD_CTRL_ADDR = 32'h50001090;
   localparam logic [31:0] USD_LINE_ADDR = 32'h50001094;
   localparam logic [31:0] USD_ISTAT_ADDR = 32'h50001098;
   localparam logic [31:0] USD_IMASK_ADDR = 32'h5000109c;
   localparam int USD_CTRL_FIFO_EN = 0;
   localparam int USD_CTRL_IR = 1;
   localparam int USD_LINE_DR = 0;
   localparam int USD_LINE_TX_HOLDING_EMPTY_FLAG = 5;
   localparam int USD_EV_OVR = 0;
   localparam int USD_EV_RX = 1;
   localparam int USD_EV_TXE = 2;
   localparam logic [7:0] USD_DATA_RST = 8'h00;
   localparam logic [2:0] USD_IMASK_RST = 3'h0;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [31:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } usd_wb_req_t;

   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } usd_wb_rsp_t;
endpackage

// >>> hdl/usd_fifo.sv
/*
 byte fifo of sixteen entries with a run-time entry limit and
 an optional overwrite of the newest entry when full.
 assumes push and pop come from logic on the same clock.
*/
`timescale 1ns/1ns
module usd_fifo
   import usd_pkg::*;
(
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input wire logic flush, // forget all entries
   input wire logic [4:0] limit, // entries allowed
   input wire logic push, // write request
   input wire logic ovw, // replace newest entry when full
   input wire logic [7:0] din, // write data
   input wire logic pop, // remove head
   output logic [7:0] dout, // head entry
   output logic empty, // no entries
   output logic full, // limit reached
   output logic [4:0] count // entries held
);
   logic [7:0] mem [USD_DEPTH];
   logic [3:0] wr_ptr;
   logic [3:0] rd_ptr;
   wire do_pop = pop && !empty;
   wire do_push = push && (!full || do_pop);
   wire do_ovw = push && full && !do_pop && ovw;
   wire [3:0] last_ptr = wr_ptr - 4'h1;

   assign empty = count == 5'h00;
   assign full = count >= limit;
   assign dout = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (srst || flush) begin
         wr_ptr <= 4'h0;
         rd_ptr <= 4'h0;
         count <= 5'h00;
      end else begin
         if (do_push) wr_ptr <= wr_ptr + 4'h1;
         if (do_pop) rd_ptr <= rd_ptr + 4'h1;
         if (do_push && !do_pop) count <= count + 5'h01;
         else if (do_pop && !do_push) count <= count - 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < USD_DEPTH; i++) mem[i] <= USD_DATA_RST;
      end else if (do_push) begin
         mem[wr_ptr] <= din;
      end else if (do_ovw) begin
         mem[last_ptr] <= din;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   drop_keep_a: assert property (push && full && !ovw && !pop && !flush |=>
      count == $past(count) && wr_ptr == $past(wr_ptr))
      else $error("write into full fifo changed it");
   ovw_last_a: assert property (push && full && ovw && !pop && !flush |=>
      mem[last_ptr] == $past(din) && count == $past(count))
      else $error("overwrite did not replace newest entry");
   cnt_bound_a: assert property (!flush |=> count <= USD_DEPTH_CNT)
      else $error("fifo count above depth");
endmodule // usd_fifo

// >>> hdl/usd_serdes.sv
/*
 8n1 serial shifter for plain uart and 3/16 infrared pulse coding.
 assumes its line inputs are already synchronised to clk.
*/
`timescale 1ns/1ns
module usd_serdes
   import usd_pkg::*;
(
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input wire logic ir_mode, // infrared coding selected
   input wire logic tx_valid, // byte offered
   input wire logic [7:0] tx_byte, // byte to send
   output logic tx_ready, // shifter idle
   output logic sout, // uart serial output
   output logic sir_out_n, // infrared output, low pulse
   input wire logic sin_s, // synced uart input
   input wire logic sir_s, // synced infrared input
   output logic rx_valid, // one-cycle byte strobe
   output logic [7:0] rx_byte // received byte
);
   logic tx_busy;
   logic [10:0] tx_cnt;
   logic [3:0] tx_slot;
   logic [9:0] tx_sh;
   logic rx_busy;
   logic [10:0] rx_cnt;
   logic [3:0] rx_slot;
   logic [7:0] rx_sh;
   logic rx_zero;
   wire tx_tick = tx_cnt == USD_BIT_LAST;
   wire tx_bit = !tx_busy || tx_sh[0];
   wire rx_tick = rx_cnt == USD_BIT_LAST;
   wire rx_start = ir_mode ? sir_s : !sin_s;
   // an infrared zero is any pulse seen during the bit time
   wire rx_bit = ir_mode ? !(rx_zero || sir_s) : sin_s;
   wire rx_data_slot = rx_slot != 4'h0 && rx_slot != USD_LAST_SLOT;

   assign tx_ready = !tx_busy;

   always_ff @(posedge clk) begin
      if (srst) begin
         tx_busy <= 1'b0;
         tx_cnt <= 11'h000;
         tx_slot <= 4'h0;
         tx_sh <= 10'h3ff;
      end else if (!tx_busy) begin
         if (tx_valid) begin
            tx_busy <= 1'b1;
            tx_sh <= {1'b1, tx_byte, 1'b0};
            tx_cnt <= 11'h000;
            tx_slot <= 4'h0;
         end
      end else if (tx_tick) begin
         tx_cnt <= 11'h000;
         tx_sh <= {1'b1, tx_sh[9:1]};
         if (tx_slot == USD_LAST_SLOT) tx_busy <= 1'b0;
         else tx_slot <= tx_slot + 4'h1;
      end else begin
         tx_cnt <= tx_cnt + 11'h001;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sout <= 1'b1;
         sir_out_n <= 1'b1;
      end else begin
         sout <= ir_mode || tx_bit;
         sir_out_n <= !(ir_mode && !tx_bit && tx_cnt < USD_IR_CYC);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rx_busy <= 1'b0;
         rx_cnt <= 11'h000;
         rx_slot <= 4'h0;
         rx_sh <= USD_DATA_RST;
         rx_zero <= 1'b0;
         rx_valid <= 1'b0;
         rx_byte <= USD_DATA_RST;
      end else begin
         rx_valid <= 1'b0;
         if (!rx_busy) begin
            if (rx_start) begin
               rx_busy <= 1'b1;
               rx_slot <= 4'h0;
               rx_cnt <= ir_mode ? 11'h001 : USD_BIT_HALF;
               rx_zero <= 1'b1;
            end
         end else if (rx_tick) begin
            rx_cnt <= 11'h000;
            rx_zero <= 1'b0;
            rx_slot <= rx_slot + 4'h1;
            if (rx_data_slot) rx_sh <= {rx_bit, rx_sh[7:1]};
            if (rx_slot == USD_LAST_SLOT) begin
               rx_busy <= 1'b0;
               rx_valid <= 1'b1;
               rx_byte <= rx_sh;
            end
         end else begin
            rx_cnt <= rx_cnt + 11'h001;
            if (sir_s) rx_zero <= 1'b1;
         end
      end
   end
endmodule // usd_serdes

// >>> hdl/usd_top.sv
/*
 serial data shadow port: sixteen aliased bus words onto the receive
 buffer and transmit holding path, with control, line status and
 interrupt registers, over a classic wishbone slave.
 assumes sin and sir_in are asynchronous pins; the bus is on clk.
*/
`timescale 1ns/1ns
module usd_top
   import usd_pkg::*;
(
   input wire logic clk, // 125 MHz clock
   input wire logic srst, // sync reset, high
   input wire usd_wb_req_t wb_req, // wishbone request
   output usd_wb_rsp_t wb_rsp, // wishbone ack and read data
   input wire logic sin, // uart serial input pin
   input wire logic sir_in, // infrared serial input pin
   output logic sout, // uart serial output pin
   output logic sir_out_n, // infrared serial output, low active
   output logic irq // level interrupt
);
   function automatic logic usd_hit(input logic [31:0] adr, input logic [31:0] reg_adr);
      usd_hit = adr[31:2] == reg_adr[31:2];
   endfunction

   function automatic logic usd_in_window(input logic [31:0] adr);
      usd_in_window = adr[31:2] >= USD_WIN_FIRST[31:2] && adr[31:2] <= USD_WIN_LAST[31:2];
   endfunction

   // pin synchronisers
   logic sin_m;
   logic sin_s;
   logic sir_m;
   logic sir_s;

   // software state
   logic fifo_en;
   logic ir_mode;
   logic [2:0] istat;
   logic [2:0] imask;
   logic tx_empty_q;

   // datapath
   logic [7:0] rx_dout;
   logic rx_empty;
   logic rx_full;
   logic [4:0] rx_count;
   logic [7:0] tx_dout;
   logic tx_empty;
   logic tx_full;
   logic [4:0] tx_count;
   logic tx_ready;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic [31:0] next_rdata;
   logic [2:0] next_istat;
   logic [2:0] next_imask;

   always_ff @(posedge clk) begin
      if (srst) begin
         sin_m <= 1'b1;
         sin_s <= 1'b1;
         sir_m <= 1'b0;
         sir_s <= 1'b0;
      end else begin
         sin_m <= sin;
         sin_s <= sin_m;
         sir_m <= sir_in;
         sir_s <= sir_m;
      end
   end

   // bus decode; a write or a pop commits on the edge that ends the ack cycle
   wire req = wb_req.cyc && wb_req.stb;
   wire acc = req && wb_rsp.ack;
   wire lane0 = wb_req.sel[0];
   wire [7:0] wdat = wb_req.dat[7:0];
   wire win_hit = usd_in_window(wb_req.adr);
   wire ctrl_hit = usd_hit(wb_req.adr, USD_CTRL_ADDR);
   wire line_hit = usd_hit(wb_req.adr, USD_LINE_ADDR);
   wire istat_hit = usd_hit(wb_req.adr, USD_ISTAT_ADDR);
   wire imask_hit = usd_hit(wb_req.adr, USD_IMASK_ADDR);
   wire win_rd = acc && win_hit && !wb_req.we;
   wire win_wr = acc && win_hit && wb_req.we && lane0;
   wire ctrl_wr = acc && ctrl_hit && wb_req.we && lane0;
   wire istat_wr = acc && istat_hit && wb_req.we && lane0;
   wire imask_wr = acc && imask_hit && wb_req.we && lane0;

   // a change of the fifo enable bit restarts both queues so a shrunken limit is never exceeded
   wire flush = ctrl_wr && wdat[USD_CTRL_FIFO_EN] != fifo_en;
   wire [4:0] q_limit = fifo_en ? USD_DEPTH_CNT : USD_ONE_CNT;
   wire q_ovw = !fifo_en;
   wire rx_pop = win_rd;
   wire tx_pop = tx_ready && !tx_empty;
   wire data_ready = !rx_empty;
   wire tx_holding_empty = tx_empty;
   wire [7:0] line_status = {2'b00, tx_holding_empty, 4'h0, data_ready};

   // events
   wire ev_ovr = rx_valid && rx_full && !rx_pop;
   wire ev_txe = tx_empty && !tx_empty_q;
   wire [2:0] events = {ev_txe, rx_valid, ev_ovr};
   wire [2:0] w1c = istat_wr ? wdat[2:0] : 3'h0;

   // set wins over a clear in the same cycle
   assign next_istat = (istat & ~w1c) | events;
   assign next_imask = imask_wr ? wdat[2:0] : imask;

   always_comb begin
      next_rdata = 32'h00000000;
      if (win_hit) begin
         next_rdata = {24'h000000, rx_dout};
      end else if (ctrl_hit) begin
         next_rdata = {30'h00000000, ir_mode, fifo_en};
      end else if (line_hit) begin
         next_rdata = {24'h000000, line_status};
      end else if (istat_hit) begin
         next_rdata = {29'h00000000, istat};
      end else if (imask_hit) begin
         next_rdata = {29'h00000000, imask};
      end
   end

   // unmapped addresses are acked and read as zero
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_rsp <= '0;
      end else begin
         wb_rsp.ack <= req && !wb_rsp.ack;
         wb_rsp.dat <= (req && !wb_rsp.ack) ? next_rdata : 32'h00000000;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         fifo_en <= 1'b0;
         ir_mode <= 1'b0;
      end else if (ctrl_wr) begin
         fifo_en <= wdat[USD_CTRL_FIFO_EN];
         ir_mode <= wdat[USD_CTRL_IR];
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         istat <= 3'h0;
         imask <= USD_IMASK_RST;
         tx_empty_q <= 1'b1;
         irq <= 1'b0;
      end else begin
         istat <= next_istat;
         imask <= next_imask;
         tx_empty_q <= tx_empty;
         irq <= |(next_istat & next_imask);
      end
   end

   usd_fifo u_rx_fifo (
      .clk(clk),
      .srst(srst),
      .flush(flush),
      .limit(q_limit),
      .push(rx_valid),
      .ovw(q_ovw),
      .din(rx_byte),
      .pop(rx_pop),
      .dout(rx_dout),
      .empty(rx_empty),
      .full(rx_full),
      .count(rx_count)
   );

   usd_fifo u_tx_fifo (
      .clk(clk),
      .srst(srst),
      .flush(flush),
      .limit(q_limit),
      .push(win_wr),
      .ovw(q_ovw),
      .din(wdat),
      .pop(tx_pop),
      .dout(tx_dout),
      .empty(tx_empty),
      .full(tx_full),
      .count(tx_count)
   );

   usd_serdes u_serdes (
      .clk(clk),
      .srst(srst),
      .ir_mode(ir_mode),
      .tx_valid(!tx_empty),
      .tx_byte(tx_dout),
      .tx_ready(tx_ready),
      .sout(sout),
      .sir_out_n(sir_out_n),
      .sin_s(sin_s),
      .sir_s(sir_s),
      .rx_valid(rx_valid),
      .rx_byte(rx_byte)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence bus_ask_s;
      req && !wb_rsp.ack;
   endsequence

   sequence win_read_s;
      bus_ask_s and (win_hit && !wb_req.we);
   endsequence

   sequence rx_into_full_s;
      rx_valid && rx_full && !rx_pop && !flush;
   endsequence

   sequence line_read_s;
      bus_ask_s and (line_hit && !wb_req.we);
   endsequence

   sequence ctrl_read_s;
      bus_ask_s and (ctrl_hit && !wb_req.we);
   endsequence

   sequence tx_room_s;
      win_wr && !tx_full && !tx_pop && !flush;
   endsequence

   sequence rx_room_s;
      rx_valid && !rx_full && !rx_pop && !flush;
   endsequence

   ack_pulse_a: assert property (bus_ask_s |=> wb_rsp.ack ##1 !wb_rsp.ack)
      else $error("ack not a single cycle after request");
   head_read_a: assert property (win_read_s |=> wb_rsp.dat[7:0] == $past(rx_dout))
      else $error("window read did not return receive head");
   high_zero_a: assert property (win_read_s |=> wb_rsp.dat[31:8] == 24'h000000)
      else $error("bits above the data byte not zero");
   ovr_flag_a: assert property (rx_into_full_s |=> istat[USD_EV_OVR])
      else $error("overrun not flagged");
   full_keep_a: assert property (rx_into_full_s and fifo_en |=>
      rx_count == $past(rx_count) && rx_dout == $past(rx_dout))
      else $error("full receive fifo altered by new byte");
   one_replace_a: assert property (rx_into_full_s and !fifo_en |=>
      rx_dout == $past(rx_byte))
      else $error("unread byte not replaced");
   tx_holding_empty_flag_clear_a: assert property (win_wr && !fifo_en && tx_empty && !flush |=>
      !tx_holding_empty)
      else $error("holding empty flag not cleared by write");
   tx_limit_a: assert property (fifo_en && !flush |=> tx_count <= USD_DEPTH_CNT)
      else $error("transmit fifo beyond sixteen");
   full_drop_a: assert property (win_wr && tx_full && !tx_pop && !flush && fifo_en |=>
      tx_count == $past(tx_count))
      else $error("write into full transmit fifo accepted");
   path_apart_a: assert property (acc && win_hit |->
      (wb_req.we ? !rx_pop : !win_wr))
      else $error("window access touched the other path");
   alias_pop_a: assert property (acc && win_hit && !wb_req.we && !rx_empty && !flush |=>
      rx_count == $past(rx_count) - 5'h01 + 5'($past(rx_valid)))
      else $error("aliased window read did not pop");
   ir_quiet_a: assert property (ir_mode ##1 ir_mode |-> sout)
      else $error("uart output moved in infrared mode");
   uart_quiet_a: assert property (!ir_mode ##1 !ir_mode |-> sir_out_n)
      else $error("infrared output pulsed in uart mode");
   irq_level_a: assert property (##1 irq == |(istat & imask))
      else $error("interrupt level does not match status and mask");
   stat_sticky_a: assert property (istat[USD_EV_RX] && !istat_wr |=> istat[USD_EV_RX])
      else $error("status bit lost without a clear");

   // software polls these two flags, so their read path is guarded directly
   line_map_a: assert property (line_read_s |=>
      wb_rsp.dat == {24'h000000, 2'b00, $past(tx_empty), 4'h0, !$past(rx_empty)})
      else $error("line status read does not match queue state");

   ctrl_back_a: assert property (ctrl_read_s |=>
      wb_rsp.dat == {30'h00000000, $past(ir_mode), $past(fifo_en)})
      else $error("control read does not match mode bits");

   idle_dat_a: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h00000000)
      else $error("read data not zero outside ack");

   // a flush wins over any push in the same cycle
   flush_empty_a: assert property (flush |=> rx_empty && tx_empty)
      else $error("mode change left entries queued");

   txe_set_a: assert property (tx_empty && !tx_empty_q |=> istat[USD_EV_TXE])
      else $error("transmit empty event not flagged");

   rx_set_a: assert property (rx_valid |=> istat[USD_EV_RX])
      else $error("received byte not flagged");

   mask_write_a: assert property (imask_wr |=> imask == $past(wdat[2:0]))
      else $error("mask write not stored");

   w1c_clear_a: assert property (istat_wr && wdat[USD_EV_OVR] && !ev_ovr |=>
      !istat[USD_EV_OVR])
      else $error("overrun flag not cleared by write one");

   tx_push_a: assert property (tx_room_s |=> tx_count == $past(tx_count) + 5'h01)
      else $error("write with room not queued");

   rx_push_a: assert property (rx_room_s |=> rx_count == $past(rx_count) + 5'h01)
      else $error("received byte with room not queued");

   rx_keep_a: assert property (bus_ask_s and wb_req.we |=> ##1
      rx_count == $past(rx_count, 2) + 5'($past(rx_valid)) + 5'($past(rx_valid, 2))
      || flush || $past(flush) || $past(rx_full) || $past(rx_full, 2))
      else $error("bus write changed the receive queue");
endmodule // usd_top

// >>> verif/usd_peer_model.sv
/*
 serial peer of the data port: sends 8n1 frames as plain uart or as
 3/16 infrared pulses, and decodes frames from the device's outputs.
 assumes the fixed bit time of the package and the bench clock.
*/
`timescale 1ns/1ns
module usd_peer_model
   import usd_pkg::*;
(
   input wire logic clk, // bench clock
   output logic sin, // uart line to device, idle high
   output logic sir_in, // infrared line to device, idle low
   input wire logic sout, // uart line from device
   input wire logic sir_out_n // infrared line from device, low pulse
);
   localparam int BIT = int'(USD_BIT_LAST) + 1;

   initial begin
      sin = 1'b1;
      sir_in = 1'b0;
   end

   // lsb first; in infrared mode a zero is a short high pulse, sin stays idle
   task automatic send_byte(input logic ir, input logic [7:0] b);
      logic [9:0] frame;
      frame = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk);
         sin <= ir | frame[i];
         sir_in <= ir & ~frame[i];
         repeat (int'(USD_IR_CYC)) @(posedge clk);
         sir_in <= 1'b0;
         repeat (BIT - 1 - int'(USD_IR_CYC)) @(posedge clk);
      end
   endtask

   // a missed start bit leaves the byte unknown, so the caller's compare fails
   task automatic recv_byte(input logic ir, output logic [7:0] b);
      int n;
      b = 8'hxx;
      n = 0;
      while ((ir ? sir_out_n : sout) !== 1'b0 && n < 40000) begin
         @(posedge clk);
         n++;
      end
      if (n < 40000) begin
         repeat (ir ? 100 : int'(USD_BIT_HALF)) @(posedge clk);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = ir ? sir_out_n : sout;
         end
         repeat (BIT) @(posedge clk);
      end
   endtask
endmodule // usd_peer_model

// >>> verif/tb_usd_top.sv
/*
 self-checking bench of the serial data shadow port over wishbone.
 assumes the peer model on the serial pins and a 125 MHz clock.
*/
`timescale 1ns/1ns
module tb_usd_top
   import usd_pkg::*;
;
   logic clk;
   logic srst;
   usd_wb_req_t wb_req;
   usd_wb_rsp_t wb_rsp;
   logic sin, sir_in, sout, sir_out_n, irq;
   int failures;
   int num_checks;
   logic [7:0] b0, b1;

   usd_top uut (.clk(clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp), .sin(sin),
      .sir_in(sir_in), .sout(sout), .sir_out_n(sir_out_n), .irq(irq));
   usd_peer_model peer (.clk(clk), .sin(sin), .sir_in(sir_in), .sout(sout),
      .sir_out_n(sir_out_n));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic results();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // entered just after a rising edge; request held until ack is sampled
   task automatic wb_xfer(input logic w, input logic [31:0] adr, input logic [31:0] wd,
      output logic [31:0] rdat);
      int n;
      n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: adr, sel: 4'hf, dat: wd};
      @(posedge clk);
      while (wb_rsp.ack !== 1'b1 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) begin
         failures++;
         results();
      end
      rdat = wb_rsp.dat;
      wb_req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [31:0] adr, input logic [7:0] d);
      logic [31:0] junk;
      wb_xfer(1'b1, adr, {24'h0, d}, junk);
   endtask

   task automatic rd_chk(input logic [31:0] adr, input logic [31:0] exp);
      logic [31:0] v;
      wb_xfer(1'b0, adr, 32'h0, v);
      check(v, exp);
   endtask

   task automatic irq_chk(input logic exp);
      repeat (2) @(posedge clk);
      check({31'h0, irq}, {31'h0, exp});
   endtask

   initial begin
      failures = 0;
      num_checks = 0;
      srst = 1'b1;
      wb_req = '0;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd_chk(USD_WIN_LAST, 32'h0);
      rd_chk(32'h50001000, 32'h0);
      rd_chk(USD_CTRL_ADDR, 32'h0);
      rd_chk(USD_LINE_ADDR, 32'h20);
      $display("test reset done");

      // fifos off: two bytes arrive unread while three writes race the shifter
      fork
         begin
            peer.send_byte(1'b0, 8'h5a);
            peer.send_byte(1'b0, 8'hc3);
         end
         begin
            wr(USD_WIN_LAST, 8'ha5);
            wr(USD_WIN_FIRST, 8'h11);
            rd_chk(USD_LINE_ADDR, 32'h0);
            wr(USD_WIN_FIRST + 32'h8, 8'h22);
         end
         begin
            peer.recv_byte(1'b0, b0);
            peer.recv_byte(1'b0, b1);
         end
      join
      check({24'h0, b0}, 32'ha5);
      check({24'h0, b1}, 32'h22);
      rd_chk(USD_LINE_ADDR, 32'h21);
      rd_chk(USD_ISTAT_ADDR, 32'h7);
      irq_chk(1'b0);
      wr(USD_IMASK_ADDR, 8'h01);
      irq_chk(1'b1);
      rd_chk(USD_WIN_LAST - 32'h4, 32'hc3);
      rd_chk(USD_LINE_ADDR, 32'h20);
      wr(USD_ISTAT_ADDR, 8'h01);
      irq_chk(1'b0);
      rd_chk(USD_ISTAT_ADDR, 32'h6);
      $display("test uart no fifo done");

      // fifos on, infrared both ways
      wr(USD_CTRL_ADDR, 8'h03);
      fork
         begin
            peer.send_byte(1'b1, 8'h96);
            peer.send_byte(1'b1, 8'h3c);
         end
         wr(USD_WIN_FIRST + 32'h4, 8'he7);
         peer.recv_byte(1'b1, b0);
      join
      check({24'h0, b0}, 32'he7);
      check({31'h0, sout}, 32'h1);
      rd_chk(USD_LINE_ADDR, 32'h21);
      rd_chk(USD_WIN_FIRST, 32'h96);
      rd_chk(USD_WIN_FIRST + 32'h38, 32'h3c);
      rd_chk(USD_LINE_ADDR, 32'h20);
      $display("test infrared fifo done");

      // one more write than shifter plus fifo can hold
      wr(USD_CTRL_ADDR, 8'h01);
      fork
         peer.recv_byte(1'b0, b0);
         begin
            for (int i = 0; i < 18; i++) begin
               wr(USD_WIN_FIRST + {26'h0, i[3:0], 2'b00}, 8'h40 + 8'(i));
            end
            rd_chk(USD_LINE_ADDR, 32'h0);
         end
      join
      check({24'h0, b0}, 32'h40);
      wr(USD_CTRL_ADDR, 8'h00);
      rd_chk(USD_LINE_ADDR, 32'h20);
      $display("test tx fifo fill done");
      results();
   end
endmodule // tb_usd_top
